/* rtl/iegc_top.sv */
// Operation
// RQ1 - Done flag in control bit 31, set by completions only, write one clears
// RQ2 - Reload request sets done when selected expander refresh finishes
// RQ3 - Test mode pin data write updates expander outputs, done on finish
// RQ4 - Writing selected expander's address runs init, done on finish
// RQ5 - Low address register holds expanders 0,1,2 at 7:1, 15:9, 23:17
// RQ6 - High address register holds expander 4 at 7:1, rest zero
// RQ7 - Polarity bit: zero gives active low pin, one active high
// RQ8 - Port 2 enable redirects its notifications onto the event pin
// RQ9 - Port 3 enable redirects its notifications onto the event pin
// RQ10 - Event pin driven only when general pin 7 uses alternate function
// RQ11 - Status bit 1 high while port 2 signals an event
// RQ12 - Status bit 2 high while port 3 signals an event
// RQ13 - Status bit never set unless that port's enable is set
// RQ14 - Reload bit launches refresh of selected expander, reads zero
// RQ15 - Select codes 0,1,2,4 choose expanders; others reserved
// RQ16 - Test mode drives expander outputs from software pin data
// RQ17 - Pin asserted while any enabled port has a pending notification; code asserts it only while gpio7_alt_en is also set
module iegc_top
  import iegc_pkg::*;
#(
  parameter int DATA_W = IEGC_DATA_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Expander bus engine
  output logic                   xfer_req,
  output logic      [1:0]        xfer_kind,
  output logic      [3:0]        xfer_sel,
  output logic      [6:0]        xfer_bus_addr,
  output logic      [DATA_W-1:0] xfer_out_data,
  input  wire logic              xfer_busy,
  input  wire logic              smb_clk_in,
  input  wire logic [DATA_W-1:0] exp_pin_in,
  input  wire logic [DATA_W-1:0] core_out_val,
  // Addresses locked against writes
  input  wire logic              addr_lock,
  // Port notifications and pin 7 function
  input  wire logic              port2_notify,
  input  wire logic              port3_notify,
  input  wire logic              gpio7_alt_en,
  output logic                   port2_notify_fwd,
  output logic                   port3_notify_fwd,
  output logic                   gp_event_pin_o,
  output logic                   gp_event_pin_oe,
  // Interrupt
  output logic                   irq
);

  // Reset release through two flops
  logic rst_m_r, rst_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_q   <= rst_m_r;
    end
  end

  // Link-side inputs cross into the core clock
  logic busy_m_r, busy_s_r, busy_d_r, sclk_m_r, sclk_s_r, sclk_d_r;
  logic [DATA_W-1:0] pin_m_r, pin_s_r;
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      busy_m_r <= 1'b0;
      busy_s_r <= 1'b0;
      busy_d_r <= 1'b0;
      // Link clock idles high; resetting low would fake a rising edge
      sclk_m_r <= 1'b1;
      sclk_s_r <= 1'b1;
      sclk_d_r <= 1'b1;
      pin_m_r  <= '0;
      pin_s_r  <= '0;
    end else begin
      busy_m_r <= xfer_busy;
      busy_s_r <= busy_m_r;
      busy_d_r <= busy_s_r;
      sclk_m_r <= smb_clk_in;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      pin_m_r  <= exp_pin_in;
      pin_s_r  <= pin_m_r;
    end
  end
  wire busy_fall = busy_d_r & ~busy_s_r;
  wire sclk_rise = sclk_s_r & ~sclk_d_r;

  // Bus decode; answer comes one cycle after the request
  wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wb_wr  = wb_req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire       wr_ctl   = wb_wr & (wb_adr_i == IEGC_OFF_CTL);
  wire       wr_addrl = wb_wr & (wb_adr_i == IEGC_OFF_ADDRL);
  wire       wr_addrh = wb_wr & (wb_adr_i == IEGC_OFF_ADDRH);
  wire       wr_gpec  = wb_wr & (wb_adr_i == IEGC_OFF_GPEC);
  wire       wr_ists  = wb_wr & (wb_adr_i == IEGC_OFF_ISTS);
  wire       wr_imsk  = wb_wr & (wb_adr_i == IEGC_OFF_IMSK);

  // Control state
  logic [3:0]        sel_r;
  logic              test_r, done_r;
  logic [DATA_W-1:0] sw_data_r, pin_state_r;
  logic [6:0]        adr0_r, adr1_r, adr2_r, adr4_r;
  logic              inv_r, p2en_r, p3en_r, p2st_r, p3st_r;
  logic [IEGC_IRQ_W-1:0] ists_r, imsk_r;
  logic [IEGC_LCNT_W-1:0] lcnt_r;
  logic              done_set;
  logic [3:0]        sel_nxt;
  // Only a control write moves the select; address writes must keep it
  assign sel_nxt = (wr_ctl & wb_sel_i[3]) ? wb_dat_i[IEGC_SEL_LO +: IEGC_SEL_W] : sel_r;

  // Triggers, judged against the select value in force after this write
  wire trig_reload = wr_ctl & wb_sel_i[3] & wb_dat_i[IEGC_RELOAD_B]; // RQ14
  wire trig_update = wr_ctl & test_r & (wb_sel_i[0] | wb_sel_i[1]); // RQ3
  wire trig_init   = (wr_addrl & wb_sel_i[0] & ~addr_lock & sel_r == IEGC_SEL_E0)
                   | (wr_addrl & wb_sel_i[1] & ~addr_lock & sel_r == IEGC_SEL_E1)
                   | (wr_addrl & wb_sel_i[2] & ~addr_lock & sel_r == IEGC_SEL_E2)
                   | (wr_addrh & wb_sel_i[0] & ~addr_lock & sel_r == IEGC_SEL_E4); // RQ4
  wire sel_ok = (sel_nxt == IEGC_SEL_E0) | (sel_nxt == IEGC_SEL_E1)
              | (sel_nxt == IEGC_SEL_E2) | (sel_nxt == IEGC_SEL_E4); // RQ15

  // Transaction sequencer
  typedef enum logic [1:0] {IEGC_IDLE, IEGC_ASK, IEGC_RUN} iegc_st_t;
  iegc_st_t st_r;
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      st_r      <= IEGC_IDLE;
      xfer_req  <= 1'b0;
      xfer_kind <= IEGC_KIND_RELOAD;
      xfer_sel  <= IEGC_SEL_E0;
    end else begin
      case (st_r)
        IEGC_IDLE: begin
          // Requests arriving while a transfer runs are dropped
          if (sel_ok & (trig_reload | trig_update | trig_init)) begin
            st_r     <= IEGC_ASK;
            xfer_req <= 1'b1;
            xfer_sel <= sel_nxt;
            if (trig_init) begin
              xfer_kind <= IEGC_KIND_INIT;
            end else if (trig_reload) begin
              xfer_kind <= IEGC_KIND_RELOAD;
            end else begin
              xfer_kind <= IEGC_KIND_UPDATE;
            end
          end
        end
        IEGC_ASK: begin
          if (busy_s_r) begin
            st_r     <= IEGC_RUN;
            xfer_req <= 1'b0;
          end
        end
        IEGC_RUN: begin
          if (busy_fall) begin
            st_r <= IEGC_IDLE;
          end
        end
        default: begin
          st_r     <= IEGC_IDLE;
          xfer_req <= 1'b0;
        end
      endcase
    end
  end
  assign done_set = (st_r == IEGC_RUN) & busy_fall; // RQ2 RQ3 RQ4

  // Expander control register
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      sel_r     <= IEGC_SEL_E0;
      test_r    <= 1'b0;
      done_r    <= 1'b0;
      sw_data_r <= '0;
    end else begin
      if (wr_ctl) begin
        sel_r  <= sel_nxt;
        test_r <= wb_sel_i[3] ? wb_dat_i[IEGC_TEST_B] : test_r;
        if (test_r) begin
          sw_data_r <= (wb_dat_i[DATA_W-1:0] & wmask[DATA_W-1:0])
                     | (sw_data_r & ~wmask[DATA_W-1:0]); // RQ16
        end
      end
      // Completion wins over a clearing write
      if (done_set) begin
        done_r <= 1'b1; // RQ1
      end else if (wr_ctl & wb_sel_i[3] & wb_dat_i[IEGC_DONE_B]) begin
        done_r <= 1'b0; // RQ1
      end
    end
  end

  // Pin state: refreshed inputs, or the outputs last sent
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      pin_state_r   <= '0;
      xfer_out_data <= '0;
    end else begin
      xfer_out_data <= test_r ? sw_data_r : core_out_val; // RQ16
      if (done_set & (xfer_kind == IEGC_KIND_RELOAD)) begin
        pin_state_r <= pin_s_r; // RQ2
      end else if (done_set & (xfer_kind == IEGC_KIND_UPDATE)) begin
        pin_state_r <= xfer_out_data;
      end
    end
  end

  // Address registers, lockable
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      adr0_r <= '0;
      adr1_r <= '0;
      adr2_r <= '0;
      adr4_r <= '0;
    end else if (!addr_lock) begin
      if (wr_addrl & wb_sel_i[0]) adr0_r <= wb_dat_i[IEGC_ADR0_LO +: IEGC_ADR_W]; // RQ5
      if (wr_addrl & wb_sel_i[1]) adr1_r <= wb_dat_i[IEGC_ADR1_LO +: IEGC_ADR_W]; // RQ5
      if (wr_addrl & wb_sel_i[2]) adr2_r <= wb_dat_i[IEGC_ADR2_LO +: IEGC_ADR_W]; // RQ5
      if (wr_addrh & wb_sel_i[0]) adr4_r <= wb_dat_i[IEGC_ADR4_LO +: IEGC_ADR_W]; // RQ6
    end
  end

  // Bus address of the expander being served
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      xfer_bus_addr <= '0;
    end else begin
      case (xfer_sel)
        IEGC_SEL_E1: xfer_bus_addr <= adr1_r;
        IEGC_SEL_E2: xfer_bus_addr <= adr2_r;
        IEGC_SEL_E4: xfer_bus_addr <= adr4_r;
        default:     xfer_bus_addr <= adr0_r;
      endcase
    end
  end

  // Event control
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      inv_r  <= 1'b0;
      p2en_r <= 1'b0;
      p3en_r <= 1'b0;
    end else if (wr_gpec & wb_sel_i[0]) begin
      inv_r  <= wb_dat_i[IEGC_INV_B];
      p2en_r <= wb_dat_i[IEGC_P2EN_B];
      p3en_r <= wb_dat_i[IEGC_P3EN_B];
    end
  end

  // Event status and pin; status follows the pending notifications, pin only in alt mode
  wire p2_pend = port2_notify & p2en_r; // RQ8 RQ13
  wire p3_pend = port3_notify & p3en_r; // RQ9 RQ13
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      p2st_r           <= 1'b0;
      p3st_r           <= 1'b0;
      port2_notify_fwd <= 1'b0;
      port3_notify_fwd <= 1'b0;
      gp_event_pin_o   <= 1'b0;
      gp_event_pin_oe  <= 1'b0;
    end else begin
      p2st_r           <= p2_pend; // RQ11
      p3st_r           <= p3_pend; // RQ12
      port2_notify_fwd <= port2_notify & ~p2en_r; // RQ8
      port3_notify_fwd <= port3_notify & ~p3en_r; // RQ9
      gp_event_pin_oe  <= gpio7_alt_en; // RQ10
      gp_event_pin_o   <= ((p2_pend | p3_pend) & gpio7_alt_en) ^ ~inv_r; // RQ7 RQ17
    end
  end

  // Interrupt status: set wins over write-one-clear
  wire [IEGC_IRQ_W-1:0] ev = {p3_pend & ~p3st_r, p2_pend & ~p2st_r, done_set};
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      ists_r <= '0;
      imsk_r <= '0;
      irq    <= 1'b0;
    end else begin
      ists_r <= ev | (ists_r & ~(wr_ists & wb_sel_i[0] ? wb_dat_i[IEGC_IRQ_W-1:0] : '0));
      if (wr_imsk & wb_sel_i[0]) imsk_r <= wb_dat_i[IEGC_IRQ_W-1:0];
      irq <= |(ists_r & imsk_r);
    end
  end

  // Link clock rising edges seen, a liveness aid for software
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      lcnt_r <= '0;
    end else if (sclk_rise) begin
      lcnt_r <= lcnt_r + 1'b1;
    end
  end

  // Read mux; unmapped words read zero
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    case (wb_adr_i)
      IEGC_OFF_CTL: begin
        rd[DATA_W-1:0] = pin_state_r;
        rd[IEGC_TEST_B] = test_r;
        rd[IEGC_SEL_LO +: IEGC_SEL_W] = sel_r;
        rd[IEGC_DONE_B] = done_r; // RQ14 reload reads zero
      end
      IEGC_OFF_ADDRL: begin
        rd[IEGC_ADR0_LO +: IEGC_ADR_W] = adr0_r;
        rd[IEGC_ADR1_LO +: IEGC_ADR_W] = adr1_r;
        rd[IEGC_ADR2_LO +: IEGC_ADR_W] = adr2_r;
      end
      IEGC_OFF_ADDRH: rd[IEGC_ADR4_LO +: IEGC_ADR_W] = adr4_r;
      IEGC_OFF_GPEC: begin
        rd[IEGC_INV_B]  = inv_r;
        rd[IEGC_P2EN_B] = p2en_r;
        rd[IEGC_P3EN_B] = p3en_r;
      end
      IEGC_OFF_GPES: begin
        rd[IEGC_P2ST_B] = p2st_r;
        rd[IEGC_P3ST_B] = p3st_r;
      end
      IEGC_OFF_ISTS: rd[IEGC_IRQ_W-1:0] = ists_r;
      IEGC_OFF_IMSK: rd[IEGC_IRQ_W-1:0] = imsk_r;
      IEGC_OFF_LCNT: rd[IEGC_LCNT_W-1:0] = lcnt_r;
      default: rd = '0;
    endcase
  end

  // Bus answer, registered
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req & ~wb_we_i ? rd : '0;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_q);

  AST_DONE_ONLY_ON_FINISH: assert property ($rose(done_r) |-> $past(done_set)) // RQ1
    else $error("done rose without a finished transfer");
  AST_DONE_SET: assert property (done_set |=> done_r) // RQ2
    else $error("finished transfer did not set done");
  AST_UPDATE_STARTS: assert property ( // RQ3
    (st_r == IEGC_IDLE) && trig_update && !trig_init && !trig_reload && sel_ok
    |=> xfer_req && xfer_kind == IEGC_KIND_UPDATE)
    else $error("test-mode data write did not start an update");
  AST_INIT_STARTS: assert property ( // RQ4
    (st_r == IEGC_IDLE) && trig_init && sel_ok |=> xfer_req && xfer_kind == IEGC_KIND_INIT)
    else $error("address write did not start init");
  AST_RELOAD_READS_ZERO: assert property ( // RQ14
    wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == IEGC_OFF_CTL)
    |-> !wb_dat_o[IEGC_RELOAD_B])
    else $error("reload bit read back as one");
  AST_LOCK_HOLDS: assert property (addr_lock |=> $stable(adr0_r) && $stable(adr4_r)) // RQ5
    else $error("locked address changed");
  AST_P2_NEEDS_EN: assert property (p2st_r |-> $past(p2en_r)) // RQ13
    else $error("port 2 status set while disabled");
  AST_P3_NEEDS_EN: assert property (p3st_r |-> $past(p3en_r)) // RQ13
    else $error("port 3 status set while disabled");
  AST_PIN_LEVEL: assert property ( // RQ7
    p2st_r && gpio7_alt_en && $past(gpio7_alt_en) && $stable(inv_r)
    |-> gp_event_pin_o == inv_r)
    else $error("event pin level wrong for polarity");
  AST_FWD_BLOCKED: assert property (p2en_r && $past(p2en_r) |-> !port2_notify_fwd) // RQ8
    else $error("port 2 notification forwarded while redirected");
  AST_PIN_OE: assert property (##1 gp_event_pin_oe == $past(gpio7_alt_en)) // RQ10
    else $error("event pin enable not following alternate function");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

endmodule

/* rtl/iegc_pkg.sv */
package iegc_pkg;
  // Register byte addresses
  localparam logic [11:0] IEGC_OFF_CTL   = 12'h350;
  localparam logic [11:0] IEGC_OFF_ADDRL = 12'h354;
  localparam logic [11:0] IEGC_OFF_ADDRH = 12'h358;
  localparam logic [11:0] IEGC_OFF_GPEC  = 12'h35c;
  localparam logic [11:0] IEGC_OFF_GPES  = 12'h360;
  localparam logic [11:0] IEGC_OFF_ISTS  = 12'h364;
  localparam logic [11:0] IEGC_OFF_IMSK  = 12'h368;
  localparam logic [11:0] IEGC_OFF_LCNT  = 12'h36c;
  // Expander control fields
  localparam int IEGC_DATA_W   = 16;
  localparam int IEGC_RELOAD_B = 24;
  localparam int IEGC_TEST_B   = 25;
  localparam int IEGC_SEL_LO   = 26;
  localparam int IEGC_SEL_W    = 4;
  localparam int IEGC_DONE_B   = 31;
  // Address fields (7 bits each, bit 0 of each byte reserved)
  localparam int IEGC_ADR_W    = 7;
  localparam int IEGC_ADR0_LO  = 1;
  localparam int IEGC_ADR1_LO  = 9;
  localparam int IEGC_ADR2_LO  = 17;
  localparam int IEGC_ADR4_LO  = 1;
  // Event control and status fields
  localparam int IEGC_INV_B    = 0;
  localparam int IEGC_P2EN_B   = 2;
  localparam int IEGC_P3EN_B   = 3;
  localparam int IEGC_P2ST_B   = 1;
  localparam int IEGC_P3ST_B   = 2;
  // Interrupt status bits
  localparam int IEGC_IRQ_W    = 3;
  localparam int IEGC_IRQ_DONE = 0;
  localparam int IEGC_IRQ_P2   = 1;
  localparam int IEGC_IRQ_P3   = 2;
  // Expander select codes
  localparam logic [3:0] IEGC_SEL_E0 = 4'h0;
  localparam logic [3:0] IEGC_SEL_E1 = 4'h1;
  localparam logic [3:0] IEGC_SEL_E2 = 4'h2;
  localparam logic [3:0] IEGC_SEL_E4 = 4'h4;
  // Transaction kinds toward the expander bus engine
  typedef enum logic [1:0] {
    IEGC_KIND_RELOAD = 2'h0,
    IEGC_KIND_UPDATE = 2'h1,
    IEGC_KIND_INIT   = 2'h2
  } iegc_kind_t;
  localparam int IEGC_LCNT_W = 16;
endpackage

/* sim/iegc_exp_model.sv */
module iegc_exp_model
  import iegc_pkg::*;
(
  // Core timing
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Request from the block
  input  wire logic                   xfer_req,
  // Bench control of answer speed and pin values
  input  wire logic                   slow,
  input  wire logic [IEGC_DATA_W-1:0] pin_val,
  // Expander side answers
  output logic                        xfer_busy,
  output logic                        smb_clk_in,
  output logic      [IEGC_DATA_W-1:0] exp_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  // One frame of two link clock periods per request
  initial begin
    xfer_busy  = 1'b0;
    smb_clk_in = 1'b1;
    exp_pin_in = '0;
    forever begin
      @(posedge core_clk);
      if (rst_n === 1'b1 && xfer_req === 1'b1) begin
        repeat (slow ? 6 : 1) @(posedge core_clk);
        xfer_busy  <= 1'b1;
        exp_pin_in <= pin_val;
        // Clock idles high, runs only inside the frame
        for (k = 0; k < 4; k++) begin
          repeat (4) @(posedge core_clk);
          smb_clk_in <= ~smb_clk_in;
        end
        repeat (2) @(posedge core_clk);
        xfer_busy <= 1'b0;
      end
    end
  end
endmodule

/* sim/ioexpander_and_gp_event_ctrl_tb.sv */
module ioexpander_and_gp_event_ctrl_tb;
  import iegc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, irq;
  logic        xfer_req, xfer_busy, smb_clk_in, addr_lock, gpio7_alt_en;
  logic        port2_notify, port3_notify, port2_notify_fwd, port3_notify_fwd;
  logic        gp_event_pin_o, gp_event_pin_oe;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, xfer_sel, s;
  logic [31:0] wb_dat_i, wb_dat_o, seed, v, a, c0;
  logic [1:0]  xfer_kind;
  logic [6:0]  xfer_bus_addr;
  logic [15:0] xfer_out_data, exp_pin_in, core_out_val, pin_val;
  int          err_total, checked, i, seen;

  iegc_top i_dut (
    .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .xfer_req, .xfer_kind, .xfer_sel,
    .xfer_bus_addr, .xfer_out_data, .xfer_busy, .smb_clk_in, .exp_pin_in,
    .core_out_val, .addr_lock, .port2_notify, .port3_notify, .gpio7_alt_en,
    .port2_notify_fwd, .port3_notify_fwd, .gp_event_pin_o, .gp_event_pin_oe, .irq
  );
  iegc_exp_model i_exp (
    .core_clk, .rst_n, .xfer_req, .slow, .pin_val, .xfer_busy, .smb_clk_in, .exp_pin_in
  );

  // Core clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected pin level: asserted low unless inverted
  function automatic logic ev_pin(input logic [31:0] r);
    return (((r[2] & r[4]) | (r[3] & r[5])) & r[6]) ^ ~r[0];
  endfunction

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [11:0] ad, input logic [31:0] d,
                    input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    wb_sel_i <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      tally_and_finish();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, ad, d, 4'hf, q);
  endtask

  task automatic rc(input logic [11:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, ad, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask

  // Poll the done flag with a bounded count
  task automatic wait_done();
    int n;
    for (n = 0; n < 100; n++) begin
      wb(1'b0, IEGC_OFF_CTL, 32'h0, 4'hf, v);
      if (v[IEGC_DONE_B] === 1'b1) break;
    end
    if (n == 100) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, addr_lock, slow, gpio7_alt_en} = '0;
    {port2_notify, port3_notify, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    core_out_val = 16'h0;
    pin_val = 16'h0;
    err_total = 0;
    checked = 0;
    seed = 32'd32;
    rst_n = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Reset state and unmapped space
    rc(IEGC_OFF_CTL, 32'h0);
    rc(IEGC_OFF_ADDRL, 32'h0);
    rc(IEGC_OFF_ADDRH, 32'h0);
    rc(IEGC_OFF_GPES, 32'h0);
    chk(gp_event_pin_o, 1'b1);
    chk(gp_event_pin_oe, 1'b0);
    wr(12'h3f0, xs());
    rc(12'h3f0, 32'h0);
    // Reserved select: nothing starts, so address writes stay quiet
    wr(IEGC_OFF_CTL, 32'h0d000000);
    seen = 0;
    repeat (20) begin
      @(posedge core_clk);
      if (xfer_req === 1'b1) seen = 1;
    end
    chk(seen, 0);
    rc(IEGC_OFF_CTL, 32'h0c000000);
    for (i = 0; i < 4; i++) begin
      a = xs();
      wr(IEGC_OFF_ADDRL, a);
      rc(IEGC_OFF_ADDRL, a & 32'h00fefefe);
      wr(IEGC_OFF_ADDRH, a);
      rc(IEGC_OFF_ADDRH, a & 32'h000000fe);
    end
    addr_lock <= 1'b1;
    wr(IEGC_OFF_ADDRL, ~a);
    rc(IEGC_OFF_ADDRL, a & 32'h00fefefe);
    addr_lock <= 1'b0;
    // Reload of expander 0, prompt answer, done raises irq
    wr(IEGC_OFF_IMSK, 32'h1);
    wb(1'b0, IEGC_OFF_LCNT, 32'h0, 4'hf, c0);
    pin_val = 16'(xs());
    wr(IEGC_OFF_CTL, 32'h01000000);
    wait_done();
    chk(v, 32'h80000000 | pin_val);
    chk(xfer_kind, IEGC_KIND_RELOAD);
    chk(xfer_sel, IEGC_SEL_E0);
    chk(irq, 1'b1);
    rc(IEGC_OFF_LCNT, (c0 + 2) & 32'hffff);
    wr(IEGC_OFF_IMSK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    wr(IEGC_OFF_ISTS, 32'h1);
    rc(IEGC_OFF_ISTS, 32'h0);
    wr(IEGC_OFF_CTL, 32'h80000000);
    rc(IEGC_OFF_CTL, pin_val);
    // Test mode update of expander 1, slow answer
    slow = 1'b1;
    core_out_val <= 16'(xs());
    wr(IEGC_OFF_CTL, 32'h06000000);
    a = xs();
    wr(IEGC_OFF_CTL, 32'h06000000 | a[15:0]);
    wait_done();
    chk(xfer_kind, IEGC_KIND_UPDATE);
    chk(xfer_sel, IEGC_SEL_E1);
    chk(xfer_out_data, a[15:0]);
    wb(1'b1, IEGC_OFF_CTL, 32'h84000000, 4'h8, v);
    repeat (2) @(posedge core_clk);
    chk(xfer_out_data, core_out_val);
    // Address write of the selected expander runs its init, codes 0, 1, 2 and 4
    for (i = 0; i < 4; i++) begin
      s = (i == 3) ? IEGC_SEL_E4 : 4'(i);
      wb(1'b1, IEGC_OFF_CTL, {2'b10, s, 26'h0}, 4'h8, v);
      a = xs();
      wr((i == 3) ? IEGC_OFF_ADDRH : IEGC_OFF_ADDRL, a);
      wait_done();
      chk(xfer_kind, IEGC_KIND_INIT);
      chk(xfer_sel, s);
      chk(xfer_bus_addr, (i == 3) ? a[7:1] : a[8*i+1 +: 7]);
    end
    wb(1'b1, IEGC_OFF_CTL, 32'h80000000, 4'h8, v);
    // Random event redirection and pin polarity
    for (i = 0; i < 40; i++) begin
      v = xs();
      wr(IEGC_OFF_GPEC, v & 32'hd);
      port2_notify <= v[4];
      port3_notify <= v[5];
      gpio7_alt_en <= v[6];
      repeat (3) @(posedge core_clk);
      chk(port2_notify_fwd, v[4] & ~v[2]);
      chk(port3_notify_fwd, v[5] & ~v[3]);
      chk(gp_event_pin_o, ev_pin(v));
      chk(gp_event_pin_oe, v[6]);
      rc(IEGC_OFF_GPEC, v & 32'hd);
      rc(IEGC_OFF_GPES, {v[3] & v[5], v[2] & v[4], 1'b0});
    end
    tally_and_finish();
  end
endmodule
